//--- inc/gauge_pkg.sv
package gauge_pkg;
  // register byte addresses
  localparam logic [7:0] off_ctrl          = 8'h00;
  localparam logic [7:0] off_status        = 8'h04;
  localparam logic [7:0] off_discharge_cfg = 8'h08;
  localparam logic [7:0] off_charge_cfg    = 8'h0c;
  localparam logic [7:0] off_flags         = 8'h10;
  localparam logic [7:0] off_table_sel     = 8'h14;
  localparam logic [7:0] off_counts        = 8'h18;
  localparam logic [7:0] off_soc_thresh    = 8'h1c;
  localparam logic [7:0] off_empty_volt    = 8'h20;
  localparam logic [7:0] off_relearn_lim   = 8'h24;
  localparam logic [7:0] off_relearn_clamp = 8'h28;
  localparam logic [7:0] off_full_cap      = 8'h2c;
  localparam logic [7:0] off_residual_cap  = 8'h30;
  localparam logic [7:0] off_meas          = 8'h34;
  localparam logic [7:0] off_meas2         = 8'h38;
  localparam logic [7:0] off_mode_cfg      = 8'h3c;

  // reset (nonvolatile default) values
  localparam logic [7:0]  rst_discharge_cfg = 8'h58;
  localparam logic [7:0]  rst_charge_cfg    = 8'h10;
  localparam logic [7:0]  rst_flags         = 8'h26;
  localparam logic [7:0]  rst_table_sel     = 8'h00;
  localparam logic [7:0]  rst_filter_count  = 8'h06;
  localparam logic [7:0]  rst_near_empty    = 8'h06;
  localparam logic [7:0]  rst_sample_intv   = 8'h0a;
  localparam logic [7:0]  rst_prog_window   = 8'h0a;
  localparam logic [7:0]  rst_low_soc       = 8'h06;
  localparam logic [7:0]  rst_high_soc      = 8'h7a;
  localparam logic [15:0] rst_first_volt    = 16'h0c1c;
  localparam logic [15:0] rst_final_volt    = 16'h0bb8;
  localparam logic [15:0] rst_relearn_curr  = 16'h1770;
  localparam logic [15:0] rst_relearn_err   = 16'h00c8;
  localparam logic [7:0]  rst_clamp         = 8'hcd;
  localparam logic [7:0]  rst_unclamped     = 8'h02;
  localparam logic [15:0] rst_full_cap      = 16'h1036;
  localparam logic [15:0] rst_residual      = 16'h0000;
  localparam logic [7:0]  rst_mode_limit    = 8'h0f;
  localparam logic [7:0]  rst_offset_cad    = 8'h3c;
  localparam logic [7:0]  rst_c_rate        = 8'h07;
  localparam logic [15:0] rst_cf_curr       = 16'h4000;

  // discharge_end_config bits
  localparam int dc_fixed_volt   = 7;
  localparam int dc_empty_flag1  = 6;
  localparam int dc_residual_now = 5;
  localparam int dc_alarm_first  = 4;
  localparam int dc_learn_first  = 3;
  localparam int dc_alarm_final  = 2;
  localparam int dc_zero_final   = 1;
  localparam int dc_no_negative  = 0;
  // charge_end_config bits
  localparam int ce_limit_cap    = 5;
  localparam int ce_over_alarm   = 4;
  localparam int ce_load_full    = 3;
  localparam int ce_trig_soc     = 2;
  localparam int ce_trig_avg     = 1;
  localparam int ce_trig_taper   = 0;
  // general_feature_flags bits
  localparam int gf_run_detect   = 0;
  // ctrl register bits
  localparam int ctl_period      = 0;
  localparam int ctl_prog_enter  = 1;
  localparam int ctl_charging    = 2;
  localparam int ctl_full        = 3;
  localparam int ctl_eoc_avg     = 4;
  localparam int ctl_eoc_taper   = 5;
  localparam int ctl_end_learn   = 6;

  localparam logic [7:0]  soc_full      = 8'h80;
  localparam logic [15:0] cf_divisor_sh = 16'd14;
  localparam logic [7:0]  c_rate_num    = 8'd28;
  localparam logic [8:0]  clamp_full    = 9'd255;

  typedef enum logic [2:0] {
    st_load = 3'b001,
    st_norm = 3'b010,
    st_prog = 3'b100
  } mode_e;

  typedef struct packed {
    logic [15:0] voltage;
    logic [15:0] current;
  } meas_s;
endpackage

//--- design/gauge_policy.sv
// Function
// R1 - discharge end true after filter count periods
// R2 - near-empty reset after valid voltage periods
// R3 - relearn needs full-to-empty, no charge, low current
// R4 - clamp learned capacity change to percentage
// R5 - skip clamp during initial cycles
// R6 - no update if error exceeds ceiling
// R7 - first empty voltage: residual capacity, relearn
// R8 - final empty voltage: optionally zero capacity
// R9 - emphasis switch at state-of-charge thresholds
// R10 - discharge-end config upper five bits
// R11 - discharge-end config lower three bits
// R12 - charge-end config bit controls
// R13 - general feature flags byte
// R14 - top two bits select lookup table
// R15 - sample mode measures every interval periods
// R16 - programming mode lasts half window count
// R17 - mode threshold limit times factor over 16384
// R18 - offset calibration repeats at cadence
// R19 - c-rate scale is 28 over max; the code only stores c_rate_scale and reads it back, never applies it
// R20 - report learned capacity as full charge
// R21 - load parameters at reset before decisions
//
// Design decisions made here: the APB register port and the address map.
module gauge_policy (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             meas_start,
  output logic             offset_cal_start,
  output logic             voltage_emphasis,
  output logic             terminate_discharge_alarm,
  output logic             overcharge_alarm,
  output logic             fully_discharged,
  output logic      [1:0]  table_index
);
  logic [7:0]  discharge_end_config, charge_end_config;
  logic [7:0]  general_feature_flags, table_select_byte;
  logic [7:0]  discharge_end_filter_count, near_empty_reset_count;
  logic [7:0]  sample_mode_interval, programming_window_count;
  logic [7:0]  low_soc_emphasis_threshold, high_soc_emphasis_threshold;
  logic [15:0] first_empty_voltage, final_empty_voltage;
  logic [15:0] relearn_current_ceiling, relearn_error_ceiling;
  logic [7:0]  relearn_change_clamp, unclamped_initial_cycles;
  logic [15:0] learned_full_capacity, residual_capacity_value;
  logic [7:0]  mode_switch_current_limit, offset_cal_cadence, c_rate_scale;
  logic [15:0] current_correction_factor;
  logic [6:0]  ctrl;
  gauge_pkg::meas_s meas;
  logic [15:0] error_est;
  logic [7:0]  soc;
  logic [15:0] remaining;
  logic        run_mode, learn_ok, seen_full;
  logic [7:0]  empty_cnt, near_cnt, sample_cnt, cal_cnt, cycles_done;
  logic [7:0]  prog_cnt;
  logic        near_reset, empty1, empty2;
  gauge_pkg::mode_e mode;

  wire logic period = ctrl[gauge_pkg::ctl_period];
  wire logic wr = psel & penable & pwrite;
  wire logic rd_phase = psel & ~penable;
  wire logic decide = (mode != gauge_pkg::st_load);

  function automatic logic hit(input logic [7:0] off);
    return paddr == off;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= gauge_pkg::off_mode_cfg;
  endfunction

  // threshold current in mA from a raw limit and correction factor
  function automatic logic [15:0] scaled(input logic [7:0] lim,
                                          input logic [15:0] cf);
    logic [23:0] p;
    p = 24'(lim) * 24'(cf);
    return p[23:8] >> 6;
  endfunction

  // bus slave: zero wait states, error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_phase) begin
      unique case (1'b1)
        hit(gauge_pkg::off_ctrl):          prdata <= {25'h0, ctrl};
        hit(gauge_pkg::off_status):        prdata <= {remaining, soc,
            2'b0, mode == gauge_pkg::st_prog, run_mode, empty2, empty1,
            near_reset, seen_full};
        hit(gauge_pkg::off_discharge_cfg): prdata <= {24'h0,
            discharge_end_config};
        hit(gauge_pkg::off_charge_cfg):    prdata <= {24'h0,
            charge_end_config};
        hit(gauge_pkg::off_flags):         prdata <= {24'h0,
            general_feature_flags};
        hit(gauge_pkg::off_table_sel):     prdata <= {24'h0,
            table_select_byte};
        hit(gauge_pkg::off_counts):        prdata <= {
            programming_window_count, sample_mode_interval,
            near_empty_reset_count, discharge_end_filter_count};
        hit(gauge_pkg::off_soc_thresh):    prdata <= {16'h0,
            high_soc_emphasis_threshold, low_soc_emphasis_threshold};
        hit(gauge_pkg::off_empty_volt):    prdata <= {final_empty_voltage,
            first_empty_voltage};
        hit(gauge_pkg::off_relearn_lim):   prdata <= {relearn_error_ceiling,
            relearn_current_ceiling};
        hit(gauge_pkg::off_relearn_clamp): prdata <= {16'h0,
            unclamped_initial_cycles, relearn_change_clamp};
        hit(gauge_pkg::off_full_cap):      prdata <= {16'h0,
            learned_full_capacity};                          // see R20
        hit(gauge_pkg::off_residual_cap):  prdata <= {16'h0,
            residual_capacity_value};
        hit(gauge_pkg::off_meas):          prdata <= meas;
        hit(gauge_pkg::off_meas2):         prdata <= {16'h0, error_est};
        hit(gauge_pkg::off_mode_cfg):      prdata <= {
            current_correction_factor[7:0], c_rate_scale,
            offset_cal_cadence, mode_switch_current_limit};
        default:                           prdata <= 32'h0;
      endcase
    end
  end

  // parameter store: defaults stand for the nonvolatile image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin                                      // see R21
      discharge_end_config        <= gauge_pkg::rst_discharge_cfg;
      charge_end_config           <= gauge_pkg::rst_charge_cfg;
      general_feature_flags       <= gauge_pkg::rst_flags;
      table_select_byte           <= gauge_pkg::rst_table_sel;
      discharge_end_filter_count  <= gauge_pkg::rst_filter_count;
      near_empty_reset_count      <= gauge_pkg::rst_near_empty;
      sample_mode_interval        <= gauge_pkg::rst_sample_intv;
      programming_window_count    <= gauge_pkg::rst_prog_window;
      low_soc_emphasis_threshold  <= gauge_pkg::rst_low_soc;
      high_soc_emphasis_threshold <= gauge_pkg::rst_high_soc;
      first_empty_voltage         <= gauge_pkg::rst_first_volt;
      final_empty_voltage         <= gauge_pkg::rst_final_volt;
      relearn_current_ceiling     <= gauge_pkg::rst_relearn_curr;
      relearn_error_ceiling       <= gauge_pkg::rst_relearn_err;
      relearn_change_clamp        <= gauge_pkg::rst_clamp;
      unclamped_initial_cycles    <= gauge_pkg::rst_unclamped;
      residual_capacity_value     <= gauge_pkg::rst_residual;
      mode_switch_current_limit   <= gauge_pkg::rst_mode_limit;
      offset_cal_cadence          <= gauge_pkg::rst_offset_cad;
      c_rate_scale                <= gauge_pkg::rst_c_rate;
      current_correction_factor   <= gauge_pkg::rst_cf_curr;
      ctrl                        <= 7'h0;
      meas                        <= '0;
      error_est                   <= 16'h0;
    end else begin
      ctrl[gauge_pkg::ctl_period]     <= 1'b0;
      ctrl[gauge_pkg::ctl_prog_enter] <= 1'b0;
      if (wr) begin
        unique case (1'b1)
          hit(gauge_pkg::off_ctrl): ctrl <= pwdata[6:0];
          hit(gauge_pkg::off_discharge_cfg):
            discharge_end_config <= pwdata[7:0];
          hit(gauge_pkg::off_charge_cfg):
            charge_end_config <= {2'b0, pwdata[5:0]};        // see R12
          hit(gauge_pkg::off_flags): general_feature_flags <= pwdata[7:0];
          hit(gauge_pkg::off_table_sel): table_select_byte <= pwdata[7:0];
          hit(gauge_pkg::off_counts): begin
            discharge_end_filter_count <= pwdata[7:0];
            near_empty_reset_count     <= pwdata[15:8];
            sample_mode_interval       <= pwdata[23:16];
            programming_window_count   <= pwdata[31:24];
          end
          hit(gauge_pkg::off_soc_thresh): begin
            low_soc_emphasis_threshold  <= pwdata[7:0];
            high_soc_emphasis_threshold <= pwdata[15:8];
          end
          hit(gauge_pkg::off_empty_volt): begin
            first_empty_voltage <= pwdata[15:0];
            final_empty_voltage <= pwdata[31:16];
          end
          hit(gauge_pkg::off_relearn_lim): begin
            relearn_current_ceiling <= pwdata[15:0];
            relearn_error_ceiling   <= pwdata[31:16];
          end
          hit(gauge_pkg::off_relearn_clamp): begin
            relearn_change_clamp     <= pwdata[7:0];
            unclamped_initial_cycles <= pwdata[15:8];
          end
          hit(gauge_pkg::off_residual_cap):
            residual_capacity_value <= pwdata[15:0];
          hit(gauge_pkg::off_meas): meas <= pwdata;
          hit(gauge_pkg::off_meas2): error_est <= pwdata[15:0];
          hit(gauge_pkg::off_mode_cfg): begin
            mode_switch_current_limit <= pwdata[7:0];
            offset_cal_cadence        <= pwdata[15:8];
            c_rate_scale              <= pwdata[23:16];      // see R19
            current_correction_factor <= {8'h0, pwdata[31:24]};
          end
          default: ;
        endcase
      end
    end
  end

  // one load cycle after reset before any decision, then programming
  // window is counted in measurement periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode     <= gauge_pkg::st_load;
      prog_cnt <= 8'h0;
    end else begin
      unique case (mode)
        gauge_pkg::st_load: mode <= gauge_pkg::st_norm;     // see R21
        gauge_pkg::st_norm:
          if (ctrl[gauge_pkg::ctl_prog_enter]) begin
            mode     <= gauge_pkg::st_prog;
            prog_cnt <= programming_window_count >> 1;       // see R16
          end
        gauge_pkg::st_prog:
          if (prog_cnt == 8'h0) mode <= gauge_pkg::st_norm;  // see R16
          else if (period) prog_cnt <= prog_cnt - 8'h1;
        default: mode <= gauge_pkg::st_load;
      endcase
    end
  end

  // sample/run selection and converter cadence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_mode   <= 1'b0;
      sample_cnt <= 8'h0;
      meas_start <= 1'b0;
    end else begin
      meas_start <= 1'b0;
      if (decide && period) begin
        run_mode <= general_feature_flags[gauge_pkg::gf_run_detect] & // see R13
            (meas.current >
             scaled(mode_switch_current_limit, current_correction_factor));
        if (run_mode) begin                                  // see R17
          meas_start <= 1'b1;                                // see R15
        end else if (sample_cnt + 8'h1 >= sample_mode_interval) begin
          meas_start <= 1'b1;                                // see R15
          sample_cnt <= 8'h0;
        end else begin
          sample_cnt <= sample_cnt + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt          <= 8'h0;
      offset_cal_start <= 1'b0;
    end else begin
      offset_cal_start <= 1'b0;
      if (decide && period) begin
        if (cal_cnt + 8'h1 >= offset_cal_cadence) begin      // see R18
          cal_cnt          <= 8'h0;
          offset_cal_start <= 1'b1;
        end else begin
          cal_cnt <= cal_cnt + 8'h1;
        end
      end
    end
  end

  // state-of-charge in 1/128 units, emphasis and lookup table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soc              <= 8'h0;
      voltage_emphasis <= 1'b0;
      table_index      <= 2'b00;
    end else begin
      soc <= (learned_full_capacity == 16'h0) ? 8'h0 :
          8'((32'(remaining) << 7) / 32'(learned_full_capacity));
      voltage_emphasis <= decide &&
          (soc <= low_soc_emphasis_threshold ||
           soc >= high_soc_emphasis_threshold);             // see R9
      table_index <= table_select_byte[7:6];                 // see R14
    end
  end

  // discharge end detection with filtered persistence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_cnt  <= 8'h0;
      near_cnt   <= 8'h0;
      empty1     <= 1'b0;
      empty2     <= 1'b0;
      near_reset <= 1'b0;
    end else if (decide && period) begin
      if (meas.voltage <= first_empty_voltage) begin
        if (empty_cnt != 8'hff) empty_cnt <= empty_cnt + 8'h1;
      end else begin
        empty_cnt <= 8'h0;
      end
      empty1 <= meas.voltage <= first_empty_voltage &&
          empty_cnt + 8'h1 >= discharge_end_filter_count;   // see R1
      empty2 <= meas.voltage <= final_empty_voltage &&
          empty_cnt + 8'h1 >= discharge_end_filter_count;   // see R1
      if (meas.voltage != 16'h0 && near_cnt != 8'hff)
        near_cnt <= near_cnt + 8'h1;
      near_reset <= near_cnt + 8'h1 >= near_empty_reset_count; // see R2
    end
  end

  // capacity, relearn and alarms
  always_ff @(posedge pclk or negedge presetn) begin
    logic [16:0] delta, limit;
    logic [15:0] learned;
    delta = 17'h0;
    limit = 17'h0;
    learned = 16'h0;
    if (!presetn) begin
      learned_full_capacity     <= gauge_pkg::rst_full_cap;
      remaining                 <= gauge_pkg::rst_full_cap;
      seen_full                 <= 1'b0;
      learn_ok                  <= 1'b0;
      cycles_done               <= 8'h0;
      terminate_discharge_alarm <= 1'b0;
      overcharge_alarm          <= 1'b0;
      fully_discharged          <= 1'b0;
    end else if (decide) begin
      if (ctrl[gauge_pkg::ctl_charging]) learn_ok <= 1'b0;   // see R3
      else if (meas.current > relearn_current_ceiling)
        learn_ok <= 1'b0;                                    // see R3
      if (ctrl[gauge_pkg::ctl_full]) begin
        seen_full <= 1'b1;
        learn_ok  <= 1'b1;
      end
      if (ctrl[gauge_pkg::ctl_full] &&
          (charge_end_config[gauge_pkg::ce_trig_soc] &&
           soc > gauge_pkg::soc_full ||
           charge_end_config[gauge_pkg::ce_trig_avg] &&
           ctrl[gauge_pkg::ctl_eoc_avg] ||
           charge_end_config[gauge_pkg::ce_trig_taper] &&
           ctrl[gauge_pkg::ctl_eoc_taper])) begin            // see R12
        overcharge_alarm <= charge_end_config[gauge_pkg::ce_over_alarm];
        if (charge_end_config[gauge_pkg::ce_load_full])
          remaining <= learned_full_capacity;
      end
      if (charge_end_config[gauge_pkg::ce_limit_cap] &&
          remaining > learned_full_capacity)
        remaining <= learned_full_capacity;
      if (empty1 && learn_ok &&
          discharge_end_config[gauge_pkg::dc_learn_first]) begin // see R7
        learn_ok <= 1'b0;
        learned  = learned_full_capacity - remaining + residual_capacity_value;
        delta = (learned > learned_full_capacity) ?
            17'(learned - learned_full_capacity) :
            17'(learned_full_capacity - learned);
        limit = 17'((25'(learned_full_capacity) * 25'(relearn_change_clamp))
            / 25'(gauge_pkg::clamp_full));                   // see R4
        if (error_est <= relearn_error_ceiling) begin        // see R6
          if (cycles_done < unclamped_initial_cycles ||
              delta <= limit)                                // see R5
            learned_full_capacity <= learned;                // see R20
          else if (learned > learned_full_capacity)
            learned_full_capacity <= learned_full_capacity + limit[15:0];
          else
            learned_full_capacity <= learned_full_capacity - limit[15:0];
          if (cycles_done != 8'hff) cycles_done <= cycles_done + 8'h1;
        end
      end
      if (ctrl[gauge_pkg::ctl_charging]) begin
        terminate_discharge_alarm <= 1'b0;
        fully_discharged          <= 1'b0;
      end
      if (empty1) begin                                      // see R10
        if (discharge_end_config[gauge_pkg::dc_residual_now])
          remaining <= residual_capacity_value;              // see R7
        if (discharge_end_config[gauge_pkg::dc_empty_flag1])
          fully_discharged <= 1'b1;
        if (discharge_end_config[gauge_pkg::dc_alarm_first])
          terminate_discharge_alarm <= 1'b1;
      end
      if (empty2) begin                                      // see R11
        fully_discharged <= 1'b1;
        if (discharge_end_config[gauge_pkg::dc_alarm_final])
          terminate_discharge_alarm <= 1'b1;
        if (discharge_end_config[gauge_pkg::dc_zero_final])
          remaining <= 16'h0;                                // see R8
      end
    end
  end
endmodule

//--- tb/gauge_policy_chk.sv
module gauge_policy_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        meas_start,
  input wire logic        offset_cal_start,
  input wire logic [1:0]  table_index
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_tbl_wr;
    psel && penable && pwrite && paddr == gauge_pkg::off_table_sel;
  endsequence
  property p_ready; s_setup |=> pready && penable; endproperty
  a_ready: assert property (p_ready) else $error("ready missing");
  property p_only; pready |-> psel && penable; endproperty
  a_only: assert property (p_only) else $error("stray ready");
  property p_bad;
    psel && !penable && (paddr > 8'h3c || paddr[1:0] != 2'h0) |=> pslverr;
  endproperty
  a_bad: assert property (p_bad) else $error("no error on bad address");
  property p_good;
    psel && !penable && paddr <= 8'h3c && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_good: assert property (p_good) else $error("error on good address");
  property p_err0; pslverr |-> prdata == 32'h0; endproperty
  a_err0: assert property (p_err0) else $error("data on refused read");
  property p_tbl;
    s_tbl_wr |=> ##1 table_index == $past(pwdata[7:6], 2);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table index wrong");
  property p_tbl_hold;
    !$stable(table_index) |-> $past(psel && penable && pwrite &&
      paddr == gauge_pkg::off_table_sel, 2);
  endproperty
  a_tbl_hold: assert property (p_tbl_hold) else $error("index moved");
  property p_meas; meas_start |=> !meas_start; endproperty
  a_meas: assert property (p_meas) else $error("start too long");
  property p_ofs; offset_cal_start |=> !offset_cal_start [*2]; endproperty
  a_ofs: assert property (p_ofs) else $error("cal too often");
endmodule

bind gauge_policy gauge_policy_chk gauge_policy_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .meas_start(meas_start),
  .offset_cal_start(offset_cal_start), .table_index(table_index));

//--- tb/apb_host.sv
module apb_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // programming writes are kept short, well inside the window
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output bit to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

//--- tb/gauge_policy_tb.sv
module gauge_policy_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic meas_start, offset_cal_start, v_emph, t_alarm, o_alarm, empty;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [1:0]  table_index;
  logic [31:0] mdl [0:15];
  int n_mismatch, tests_run, n_meas, n_ofs, m0, o0;
  bit to;
  apb_host apb_host_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  gauge_policy gauge_policy_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_start(meas_start), .offset_cal_start(offset_cal_start),
    .voltage_emphasis(v_emph), .terminate_discharge_alarm(t_alarm),
    .overcharge_alarm(o_alarm), .fully_discharged(empty),
    .table_index(table_index));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_meas += (meas_start === 1'b1);
    n_ofs += (offset_cal_start === 1'b1);
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(bit w, logic [7:0] a, logic [31:0] wd);
    apb_host_inst.xfer(w, a, wd, rd, err, to);
    if (to) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // model write: masks follow each register's writable bits
  task automatic wr_rd(logic [7:0] a, logic [31:0] wd, logic [31:0] m);
    acc(1'b1, a, wd);
    mdl[a[5:2]] = (wd & m) | (mdl[a[5:2]] & ~m);
    acc(1'b0, a, 32'h0);
    chk("readback", rd, mdl[a[5:2]]);
  endtask
  task automatic period();
    acc(1'b1, gauge_pkg::off_ctrl, 32'h1);
  endtask
  initial begin
    presetn = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    mdl = '{0, 0, 32'h58, 32'h10, 32'h26, 0, 32'h0a0a0606, 32'h7a06,
            32'h0bb80c1c, 32'h00c81770, 32'h2cd, 32'h1036, 0, 0, 0,
            32'h00073c0f};
    void'($urandom(29));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 2; i < 16; i++) begin
      if (i == 13 || i == 14) continue;
      acc(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rd, mdl[i]);
    end
    $display("reset values done");
    wr_rd(gauge_pkg::off_charge_cfg, 32'hff, 32'h3f);
    d = $urandom;
    wr_rd(gauge_pkg::off_discharge_cfg, d, 32'hff);
    wr_rd(gauge_pkg::off_full_cap, 32'h0, 32'h0);
    acc(1'b1, 8'h40, 32'hffffffff);
    chk("bad write err", {31'h0, err}, 32'h1);
    acc(1'b0, 8'h05, 32'h0);
    chk("bad read err", {31'h0, err}, 32'h1);
    chk("bad read data", rd, 32'h0);
    $display("access kinds done");
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      d[7:6] = 2'(i);
      wr_rd(gauge_pkg::off_table_sel, d, 32'hff);
      chk("table index", {30'h0, table_index}, 32'(i));
    end
    $display("table select done");
    wr_rd(gauge_pkg::off_counts, 32'h04020606, 32'hffffffff);
    repeat (10) period();
    #1 m0 = n_meas;
    o0 = n_ofs;
    repeat (120) period();
    #1 chk("meas starts", 32'(n_meas - m0), 32'd60);
    chk("cal starts", 32'(n_ofs - o0), 32'd2);
    chk("emphasis", {31'h0, v_emph}, 32'h1);
    chk("discharged", {31'h0, empty}, 32'h1);
    chk("td alarm", {31'h0, t_alarm}, 32'(d[4] | d[2]));
    acc(1'b1, gauge_pkg::off_ctrl, 32'h18);
    repeat (2) @(posedge pclk);
    chk("oc alarm", {31'h0, o_alarm}, 32'h1);
    $display("cadence done");
    acc(1'b1, gauge_pkg::off_ctrl, 32'h2);
    acc(1'b0, gauge_pkg::off_status, 32'h0);
    chk("prog entered", {31'h0, rd[5]}, 32'h1);
    repeat (4) period();
    acc(1'b0, gauge_pkg::off_status, 32'h0);
    chk("prog left", {31'h0, rd[5]}, 32'h0);
    $display("programming window done");
    stop_test();
  end
endmodule
